// ===== fcec_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// behavioural card: one flash device, 64 bytes, 8-byte blocks
module fcec_card_model
#(
   parameter int  ERASE_CYC = 200,
   parameter int  WRITE_CYC = 60,
   parameter real WAKE_NS   = 20.0
)
(
   // clock for the algorithm timer and the last-read latch
   input  wire logic        clk_i,
   // card pins
   input  wire logic [25:0] addr_i,
   input  wire logic [15:0] dq_i,
   output logic      [15:0] dq_o,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        ce0_n_i,
   input  wire logic        ce1_n_i,
   input  wire logic        reset_i,
   output logic             busy_n_o,
   // failure bits forced into the next completion
   input  wire logic [7:0]  inject_i
);
   logic [7:0]  mem [64];
   logic [7:0]  stat = 8'h80;
   logic [7:0]  wdat = 8'h00;
   logic [7:0]  setup = 8'h00;
   logic [5:0]  wadr = 6'h00;
   logic        st_mode = 1'b0;
   logic        busy = 1'b0;
   logic        susp = 1'b0;
   logic        is_erase = 1'b0;
   logic [15:0] last = 16'h0000;
   int          cnt = 0;
   int          viol = 0;
   realtime     t_rise = 0;
   realtime     t_fall = -1000;
   wire         sel = ~(ce0_n_i & ce1_n_i);
   wire         rd = sel & ~oe_n_i & ~reset_i;

   initial
      for (int i = 0; i < 64; i++)
         mem[i] = 8'(i) ^ 8'ha5;

   // released lines show the inverse of the last value, not a lucky match
   always_comb
   begin
      if (!rd)
         dq_o = ~last;
      else if (st_mode)
         dq_o = {8'h00, (busy && !susp) ? {1'b0, 7'(cnt)} : stat};
      else
         dq_o = {~last[15:8], mem[addr_i[5:0]]};
   end
   always @(posedge clk_i)
      if (rd)
         last <= dq_o;

   assign busy_n_o = ~busy;

   task automatic start(input logic er, input logic [5:0] a);
      if (busy)
         viol++;
      busy = 1'b1;
      susp = 1'b0;
      is_erase = er;
      wadr = a;
      cnt = er ? ERASE_CYC : WRITE_CYC;
      stat = 8'h00;
   endtask : start

   task automatic start_bg(input logic er, input logic [5:0] a, input logic [7:0] d);
      wdat = d;
      start(er, a);
   endtask : start_bg

   always @(posedge reset_i)
      t_rise = $realtime;
   always @(negedge reset_i)
   begin
      if ($realtime - t_rise < 100.0)
         viol++;
      t_fall = $realtime;
   end
   // enables follow the strobes by a cycle, so their fall counts as the access too
   always @(negedge oe_n_i, negedge we_n_i, posedge sel)
      if (sel && !(oe_n_i && we_n_i) && (reset_i || $realtime - t_fall < WAKE_NS))
         viol++;

   // data and commands are taken at the rising write strobe
   always @(posedge we_n_i)
   begin
      if (sel && !reset_i)
      begin
         if (setup != 8'h00)
         begin
            st_mode = 1'b1;
            if (setup == 8'h40)
            begin
               wdat = dq_i[7:0];
               start(1'b0, addr_i[5:0]);
            end
            else if (dq_i[7:0] == 8'hd0)
               start(1'b1, addr_i[5:0]);
            else
               stat = 8'hb0;
            setup = 8'h00;
         end
         else
         begin
            if (susp && !(dq_i[7:0] inside {8'hff, 8'h98, 8'h70, 8'h50, 8'hb8, 8'hd0, 8'h40, 8'h10}))
               viol++;
            case (dq_i[7:0])
               8'hff: st_mode = 1'b0;
               8'h70: st_mode = 1'b1;
               8'h50: stat = 8'h80;
               8'h20, 8'h40: setup = dq_i[7:0];
               8'h10: setup = 8'h40;
               8'hb0:
                  if (busy && !susp)
                  begin
                     susp = 1'b1;
                     st_mode = 1'b1;
                     stat = is_erase ? 8'hc0 : 8'h84;
                  end
               8'hd0:
                  if (susp)
                  begin
                     susp = 1'b0;
                     st_mode = 1'b1;
                     stat = 8'h00;
                  end
               default: ;
            endcase
         end
      end
   end

   // timer steps on the falling edge so the controller never samples a half-updated status
   always @(negedge clk_i)
   begin
      if (reset_i)
      begin
         if (busy && is_erase)
            for (int i = 0; i < 8; i++)
               mem[{wadr[5:3], 3'(i)}] = 8'h00;
         busy = 1'b0;
         susp = 1'b0;
         setup = 8'h00;
         st_mode = 1'b0;
         stat = 8'h80;
      end
      else if (busy && !susp)
      begin
         if (cnt > 1)
            cnt--;
         else
         begin
            if (is_erase)
               for (int i = 0; i < 8; i++)
                  mem[{wadr[5:3], 3'(i)}] = 8'hff;
            else
               mem[wadr] = wdat;
            stat = 8'h80 | inject_i;
            busy = 1'b0;
         end
      end
   end
endmodule : fcec_card_model
`default_nettype wire

// ===== fcec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fcec_ctrl
#(
   parameter int WAKE_CYCLES = fcec_pkg::WAKE_CYC
)
(
   // system
   input  wire logic                clk_sys_i,
   input  wire logic                arst_n_i,
   // user orders
   input  wire logic                req_i,
   input  wire fcec_pkg::fcec_op_type op_i,
   input  wire logic [25:0]         addr_i,
   input  wire logic [15:0]         data_i,
   output logic                     ack_o,
   output logic                     busy_o,
   output logic [15:0]              rdata_o,
   output logic [7:0]               status_o,
   output logic                     fail_o,
   // card pins
   output logic [25:0]              card_addr_o,
   output logic [15:0]              card_dq_o,
   output logic                     card_dq_oe_o,
   input  wire logic [15:0]         card_dq_i,
   output logic                     card_we_n_o,
   output logic                     card_oe_n_o,
   output logic                     card_enable_even_byte_n_o,
   output logic                     card_enable_odd_byte_n_o,
   output logic                     card_reset_o,
   input  wire logic                ready_busy_output_n_i
);
   typedef enum logic [3:0]
   {
      S_RESET, S_WAKE, S_IDLE, S_CMD1, S_CMD2, S_POLL, S_POLL_RD, S_DONE
   } fcec_state_type;

   // ==========================================================
   // state
   fcec_state_type              st_r, st_nxt;
   fcec_pkg::fcec_op_type       op_r, op_nxt;
   logic [25:0]                 adr_r, adr_nxt;
   logic [15:0]                 dat_r, dat_nxt;
   logic [15:0]                 cnt_r, cnt_nxt;
   logic [15:0]                 rd_r, rd_nxt;
   logic [7:0]                  sts_r, sts_nxt;
   logic                        ack_nxt, rst_nxt;
   logic                        cyc_start, cyc_wr, cyc_busy, cyc_done, ce_n;
   logic [15:0]                 cyc_wdata, cyc_rdata, cyc_dq;

   fcec_cycle #(.STROBE(fcec_pkg::STROBE_CYC)) u_cycle
   (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .start_i   (cyc_start),
      .write_i   (cyc_wr),
      .wdata_i   (cyc_wdata),
      .bus_din_i (card_dq_i),
      .busy_o    (cyc_busy),
      .done_o    (cyc_done),
      .we_n_o    (card_we_n_o),
      .oe_n_o    (card_oe_n_o),
      .ce_n_o    (ce_n),
      .dq_oe_o   (card_dq_oe_o),
      .dq_o      (cyc_dq),
      .rdata_o   (cyc_rdata)
   );

   // ==========================================================
   // sequencer
   always_comb
   begin
      st_nxt    = st_r;
      op_nxt    = op_r;
      adr_nxt   = adr_r;
      dat_nxt   = dat_r;
      cnt_nxt   = cnt_r;
      rd_nxt    = rd_r;
      sts_nxt   = sts_r;
      ack_nxt   = 1'b0;
      rst_nxt   = 1'b0;
      cyc_start = 1'b0;
      cyc_wr    = 1'b1;
      cyc_wdata = 16'h0000;
      case (st_r)
         S_RESET:
         begin
            // card reset follows system reset, held past the minimum width
            rst_nxt = 1'b1;
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r >= 16'(fcec_pkg::RESET_PULSE_CYC))
            begin
               rst_nxt = 1'b0;
               cnt_nxt = 16'h0000;
               st_nxt  = S_WAKE;
            end
         end
         S_WAKE:
         begin
            // no access until wake-up elapses; devices then sit in read array
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r >= 16'(WAKE_CYCLES))
               st_nxt = (op_r == fcec_pkg::OP_POWERDOWN) ? S_DONE : S_IDLE;
         end
         S_IDLE:
         begin
            if (req_i)
            begin
               op_nxt  = op_i;
               adr_nxt = addr_i;
               dat_nxt = data_i;
               cnt_nxt = 16'h0000;
               // power-down aborts any running operation
               st_nxt  = (op_i == fcec_pkg::OP_POWERDOWN) ? S_RESET : S_CMD1;
            end
         end
         S_CMD1:
         begin
            // done and idle coincide for a cycle; without the done term a cycle goes out twice
            cyc_start = !cyc_busy && !cyc_done;
            case (op_r)
               fcec_pkg::OP_ERASE:   cyc_wdata = {8'h00, fcec_pkg::CMD_ERASE_SETUP};
               fcec_pkg::OP_WRITE:   cyc_wdata = {8'h00, fcec_pkg::CMD_WRITE_SETUP};
               fcec_pkg::OP_SUSPEND: cyc_wdata = {8'h00, fcec_pkg::CMD_SUSPEND};
               fcec_pkg::OP_RESUME:  cyc_wdata = {8'h00, fcec_pkg::CMD_RESUME};
               fcec_pkg::OP_CLEAR:   cyc_wdata = {8'h00, fcec_pkg::CMD_CLEAR_STATUS};
               fcec_pkg::OP_STATUS:  cyc_wdata = {8'h00, fcec_pkg::CMD_READ_STATUS};
               default:              cyc_wdata = {8'h00, fcec_pkg::CMD_READ_ARRAY};
            endcase
            if (cyc_done)
            begin
               case (op_r)
                  fcec_pkg::OP_ERASE, fcec_pkg::OP_WRITE, fcec_pkg::OP_READ: st_nxt = S_CMD2;
                  fcec_pkg::OP_CLEAR:
                  begin
                     sts_nxt = 8'h00;
                     st_nxt  = S_DONE;
                  end
                  fcec_pkg::OP_RESUME:
                  begin
                     // erase or write runs again: ready and both suspend bits read low
                     sts_nxt = 8'h00;
                     st_nxt  = S_POLL;
                  end
                  default: st_nxt = S_POLL;
               endcase
            end
         end
         S_CMD2:
         begin
            cyc_start = !cyc_busy && !cyc_done;
            cyc_wr    = (op_r != fcec_pkg::OP_READ);
            // confirm and data go to the same block/word address
            cyc_wdata = (op_r == fcec_pkg::OP_ERASE) ? {8'h00, fcec_pkg::CMD_CONFIRM} : dat_r;
            if (cyc_done)
            begin
               rd_nxt = cyc_rdata;
               st_nxt = (op_r == fcec_pkg::OP_READ) ? S_DONE : S_POLL;
            end
         end
         S_POLL:
         begin
            // device stays in status mode, so plain reads give status
            cyc_start = !cyc_busy && !cyc_done;
            cyc_wr    = 1'b0;
            if (cyc_done)
               st_nxt = S_POLL_RD;
         end
         S_POLL_RD:
         begin
            // lower bits only trusted once ready reads high
            if (cyc_rdata[fcec_pkg::BIT_READY] && ready_busy_output_n_i)
            begin
               sts_nxt = cyc_rdata[7:0];
               st_nxt  = S_DONE;
            end
            else if (cyc_rdata[fcec_pkg::BIT_READY] &&
                     (cyc_rdata[fcec_pkg::BIT_WRITE_SUSP] || cyc_rdata[fcec_pkg::BIT_ERASE_SUSP]))
            begin
               // busy pin stays low through an erase or write suspend, so trust the bits
               sts_nxt = cyc_rdata[7:0];
               st_nxt  = S_DONE;
            end
            else
            begin
               sts_nxt = {cyc_rdata[7], 7'h00};
               st_nxt  = S_POLL;
            end
         end
         S_DONE:
         begin
            ack_nxt = 1'b1;
            st_nxt  = S_IDLE;
         end
         default: st_nxt = S_RESET;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_r         <= S_RESET;
         op_r         <= fcec_pkg::OP_READ;
         adr_r        <= 26'h0000000;
         dat_r        <= 16'h0000;
         cnt_r        <= 16'h0000;
         rd_r         <= 16'h0000;
         sts_r        <= 8'h00;
         ack_o        <= 1'b0;
         card_reset_o <= 1'b1;
         card_addr_o  <= 26'h0000000;
         card_dq_o    <= 16'h0000;
         card_enable_even_byte_n_o <= 1'b1;
         card_enable_odd_byte_n_o  <= 1'b1;
         busy_o       <= 1'b1;
         rdata_o      <= 16'h0000;
         status_o     <= 8'h00;
         fail_o       <= 1'b0;
      end
      else
      begin
         st_r         <= st_nxt;
         op_r         <= op_nxt;
         adr_r        <= adr_nxt;
         dat_r        <= dat_nxt;
         cnt_r        <= cnt_nxt;
         rd_r         <= rd_nxt;
         sts_r        <= sts_nxt;
         ack_o        <= ack_nxt;
         card_reset_o <= rst_nxt;
         card_addr_o  <= adr_r;
         card_dq_o    <= cyc_dq;
         // both enables high while idle gives standby; the one picked by address bit 0 goes low to access
         card_enable_even_byte_n_o <= ce_n || adr_r[0];
         card_enable_odd_byte_n_o  <= ce_n || !adr_r[0];
         busy_o       <= (st_nxt != S_IDLE);
         rdata_o      <= rd_r;
         status_o     <= sts_r;
         fail_o       <= |(sts_r & fcec_pkg::FAIL_MASK);
      end
   end

   // ==========================================================
   // checks
   reset_width_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      $fell(card_reset_o) |-> $past(st_r) == S_RESET &&
      $past(cnt_r) >= 16'(fcec_pkg::RESET_PULSE_CYC)) else $error("reset released early");
   wake_wait_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == S_WAKE) |-> card_enable_even_byte_n_o && card_enable_odd_byte_n_o)
      else $error("access during wake-up");
   standby_idle_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == S_IDLE && !cyc_busy) |=> ##1 card_enable_odd_byte_n_o && card_enable_even_byte_n_o)
      else $error("card enabled while idle");
   status_gate_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == S_POLL_RD && !cyc_rdata[7]) |=> sts_r[6:0] == 7'h00)
      else $error("low status bits kept while busy");
   clear_zero_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == S_CMD1 && op_r == fcec_pkg::OP_CLEAR && cyc_done) |=> sts_r == 8'h00)
      else $error("clear status left bits");
   wr_no_read_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      !card_we_n_o |-> card_oe_n_o && card_dq_oe_o) else $error("write strobe without drive");
   ack_after_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == S_DONE) |=> ack_o) else $error("missing ack");
   fail_flag_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ##1 fail_o == $past(|(sts_r & fcec_pkg::FAIL_MASK)))
      else $error("fail flag wrong");
endmodule : fcec_ctrl
`default_nettype wire

// ===== fcec_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// one card bus cycle: strobe low for a fixed count, data taken at the end
module fcec_cycle
#(
   parameter int STROBE = 20
)
(
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   input  wire logic        start_i,
   input  wire logic        write_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic [15:0] bus_din_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             we_n_o,
   output logic             oe_n_o,
   output logic             ce_n_o,
   output logic             dq_oe_o,
   output logic [15:0]      dq_o,
   output logic [15:0]      rdata_o
);
   logic [7:0]  cnt_r, cnt_nxt;
   logic        act_r, act_nxt, wr_r, wr_nxt, done_nxt;
   logic [15:0] dq_nxt, rd_nxt;

   always_comb
   begin
      cnt_nxt  = cnt_r;
      act_nxt  = act_r;
      wr_nxt   = wr_r;
      dq_nxt   = dq_o;
      rd_nxt   = rdata_o;
      done_nxt = 1'b0;
      if (!act_r && start_i)
      begin
         act_nxt = 1'b1;
         wr_nxt  = write_i;
         dq_nxt  = wdata_i;
         cnt_nxt = 8'(STROBE);
      end
      else if (act_r)
      begin
         if (cnt_r == 8'h00)
         begin
            // strobe rises here, so write data is latched on that edge
            act_nxt  = 1'b0;
            done_nxt = 1'b1;
            if (!wr_r)
               rd_nxt = bus_din_i;
         end
         else
            cnt_nxt = cnt_r - 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt_r   <= 8'h00;
         act_r   <= 1'b0;
         wr_r    <= 1'b0;
         done_o  <= 1'b0;
         dq_o    <= 16'h0000;
         rdata_o <= 16'h0000;
         we_n_o  <= 1'b1;
         oe_n_o  <= 1'b1;
         ce_n_o  <= 1'b1;
         dq_oe_o <= 1'b0;
      end
      else
      begin
         cnt_r   <= cnt_nxt;
         act_r   <= act_nxt;
         wr_r    <= wr_nxt;
         done_o  <= done_nxt;
         dq_o    <= dq_nxt;
         rdata_o <= rd_nxt;
         we_n_o  <= !(act_nxt && wr_nxt);
         oe_n_o  <= !(act_nxt && !wr_nxt);
         // both enables high between cycles keeps idle devices in standby
         ce_n_o  <= !act_nxt;
         // drive held one cycle past the strobe rise so the latch never sees a released bus
         dq_oe_o <= (act_nxt && wr_nxt) || (act_r && wr_r);
      end
   end

   assign busy_o = act_r;
endmodule : fcec_cycle
`default_nettype wire

// ===== fcec_pkg.sv
package fcec_pkg;
   // ==========================================================
   // command codes, written on the low data byte
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
   localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
   localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
   localparam logic [7:0] CMD_RESUME       = 8'hd0;
   // ==========================================================
   // status bit positions
   localparam int BIT_READY       = 7;
   localparam int BIT_ERASE_SUSP  = 6;
   localparam int BIT_ERASE_ERR   = 5;
   localparam int BIT_PROG_ERR    = 4;
   localparam int BIT_LOW_VOLT    = 3;
   localparam int BIT_WRITE_SUSP  = 2;
   localparam int BIT_LOCK        = 1;
   localparam logic [7:0] FAIL_MASK = 8'h3a;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int RESET_PULSE_NS   = 100;
   localparam int RESET_PULSE_CYC  = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_NS          = 1000;
   localparam int WAKE_CYC         = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_CYC       = 20;
   // ==========================================================
   // user operations
   typedef enum logic [2:0]
   {
      OP_READ, OP_ERASE, OP_WRITE, OP_SUSPEND, OP_RESUME, OP_CLEAR, OP_STATUS, OP_POWERDOWN
   } fcec_op_type;
endpackage : fcec_pkg

// ===== flash_card_erase_write_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_card_erase_write_control_bench;
   logic                  clk = 1'b0;
   logic                  arst_n = 1'b0;
   logic                  req = 1'b0;
   fcec_pkg::fcec_op_type op = fcec_pkg::OP_READ;
   logic [25:0]           addr = 26'h0;
   logic [15:0]           wdata = 16'h0;
   logic [7:0]            inject = 8'h00;
   logic                  ack, busy, fail, dq_oe, we_n, oe_n, ce0_n, ce1_n, card_rst, rb_n;
   logic [15:0]           rdata, dq_c, dq_m, dq_bus;
   logic [7:0]            status;
   logic [25:0]           card_addr;
   logic [7:0]            codes [4] = '{8'h20, 8'h08, 8'h02, 8'h30};
   int                    num_errors = 0;
   int                    checked = 0;

   assign dq_bus = dq_oe ? dq_c : dq_m;
   always #2.5 clk = ~clk;

   fcec_ctrl #(.WAKE_CYCLES(4)) dut_u (
      .clk_sys_i(clk), .arst_n_i(arst_n), .req_i(req), .op_i(op), .addr_i(addr),
      .data_i(wdata), .ack_o(ack), .busy_o(busy), .rdata_o(rdata), .status_o(status),
      .fail_o(fail), .card_addr_o(card_addr), .card_dq_o(dq_c), .card_dq_oe_o(dq_oe),
      .card_dq_i(dq_bus), .card_we_n_o(we_n), .card_oe_n_o(oe_n),
      .card_enable_even_byte_n_o(ce0_n), .card_enable_odd_byte_n_o(ce1_n),
      .card_reset_o(card_rst), .ready_busy_output_n_i(rb_n));

   fcec_card_model model_u (
      .clk_i(clk), .addr_i(card_addr), .dq_i(dq_bus), .dq_o(dq_m), .we_n_i(we_n),
      .oe_n_i(oe_n), .ce0_n_i(ce0_n), .ce1_n_i(ce1_n), .reset_i(card_rst),
      .busy_n_o(rb_n), .inject_i(inject));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   // every wait is bounded; a hang counts as a mismatch
   task automatic tick(inout int n);
      @(negedge clk);
      n++;
      if (n > 30000)
      begin
         num_errors++;
         $display("BAD handshake wait expected ack seen none");
         test_done();
      end
   endtask : tick

   task automatic run(input fcec_pkg::fcec_op_type o, input logic [25:0] a,
                      input logic [15:0] d);
      int n;
      n = 0;
      while (busy !== 1'b0)
         tick(n);
      op = o;
      addr = a;
      wdata = d;
      req = 1'b1;
      tick(n);
      // busy was low, so the edge just passed took the order
      req = 1'b0;
      while (ack !== 1'b1)
         tick(n);
   endtask : run

   task automatic rd(input logic [25:0] a, input logic [7:0] exp);
      run(fcec_pkg::OP_READ, a, 16'h0);
      check("read byte", {8'h00, rdata[7:0]}, {8'h00, exp});
   endtask : rd

   task automatic suspended(input logic er, input logic [5:0] a, input logic [7:0] d);
      model_u.start_bg(er, a, d);
      run(fcec_pkg::OP_SUSPEND, 26'(a), 16'h0);
      check("suspend status", {8'h00, status}, er ? 16'h00c0 : 16'h0084);
      check("busy pin in suspend", {15'h0, rb_n}, 16'h0000);
   endtask : suspended

   initial
   begin
      repeat (6) @(negedge clk);
      check("card reset in system reset", {15'h0, card_rst}, 16'h0001);
      check("busy in reset", {15'h0, busy}, 16'h0001);
      arst_n = 1'b1;
      rd(26'h11, 8'hb4);
      check("enables idle", {14'h0, ce1_n, ce0_n}, 16'h0003);
      run(fcec_pkg::OP_WRITE, 26'h5, 16'h003c);
      check("write status", {8'h00, status}, 16'h0080);
      check("write fail", {15'h0, fail}, 16'h0000);
      rd(26'h5, 8'h3c);
      run(fcec_pkg::OP_ERASE, 26'h2, 16'h0);
      check("erase status", {8'h00, status}, 16'h0080);
      check("busy pin after erase", {15'h0, rb_n}, 16'h0001);
      rd(26'h5, 8'hff);
      rd(26'h8, 8'had);
      for (int i = 0; i < 4; i++)
      begin
         inject = codes[i];
         run(fcec_pkg::OP_ERASE, 26'h8, 16'h0);
         inject = 8'h00;
         check("failure status", {8'h00, status}, {8'h00, 8'h80 | codes[i]});
         check("fail flag", {15'h0, fail}, 16'h0001);
         run(fcec_pkg::OP_STATUS, 26'h8, 16'h0);
         check("sticky status", {8'h00, status}, {8'h00, 8'h80 | codes[i]});
         run(fcec_pkg::OP_CLEAR, 26'h8, 16'h0);
         check("cleared status", {8'h00, status}, 16'h0000);
      end
      suspended(1'b1, 6'd24, 8'h00);
      rd(26'h11, 8'hb4);
      run(fcec_pkg::OP_RESUME, 26'd24, 16'h0);
      check("erase resumed", {8'h00, status}, 16'h0080);
      rd(26'd27, 8'hff);
      suspended(1'b0, 6'd40, 8'h77);
      rd(26'h11, 8'hb4);
      run(fcec_pkg::OP_RESUME, 26'd40, 16'h0);
      check("write resumed", {8'h00, status}, 16'h0080);
      rd(26'd40, 8'h77);
      suspended(1'b1, 6'd56, 8'h00);
      run(fcec_pkg::OP_POWERDOWN, 26'h0, 16'h0);
      check("busy pin after abort", {15'h0, rb_n}, 16'h0001);
      run(fcec_pkg::OP_STATUS, 26'h0, 16'h0);
      check("status after wake", {8'h00, status}, 16'h0080);
      rd(26'h1, 8'hff);
      @(negedge clk);
      arst_n = 1'b0;
      @(negedge clk);
      check("card reset mid run", {15'h0, card_rst}, 16'h0001);
      arst_n = 1'b1;
      rd(26'h11, 8'hb4);
      check("card pin faults", 16'(model_u.viol), 16'h0000);
      test_done();
   end
endmodule : flash_card_erase_write_control_bench
`default_nettype wire
